// File: verilog/dsd_pkg.sv
package dsd_pkg;
  localparam int EA_W = 16;
  localparam int PAGE_W = 8;
  localparam int PROG_ADDR_W = 23;
  localparam int PROG_WORD_W = 24;
  localparam int DATA_W = 16;
  localparam int WIN_LOW_W = 15;
  localparam logic [15:0] SFR_BASE = 16'h0000;
  localparam logic [15:0] SFR_LAST = 16'h07ff;
  localparam logic [15:0] WIN_BASE = 16'h8000;
  localparam int SFR_BLOCK_BYTES = 32;
  localparam int SFR_BLOCK_SHIFT = 5;
  localparam int SFR_BLOCKS = 64;
  localparam int CORE_CTRL_WIN_BIT = 2;
  // One bit per 32-byte block, block 0 at bit 0
  // Core spans three blocks and interrupts three; the block at 0E0h stays empty
  localparam logic [63:0] SFR_BLOCK_MAP = 64'h0c02_0040_0143_157f;
  localparam logic [15:0] READ_DATA_RST = 16'h0000;
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_ONE = 2'h1;
  localparam logic [1:0] EXTRA_TWO = 2'h2;
  typedef enum logic [1:0] {
    DSD_RT_RAM = 2'h0,
    DSD_RT_SFR = 2'h1,
    DSD_RT_PROG = 2'h3
  } dsd_route_t;
endpackage

// File: verilog/dsd_decoder.sv
`timescale 1ns/1ps
// Functional notes
// [RULE_01] Addresses 0000h to 07FFh form the special function register region.
// [RULE_02] A read of an unimplemented register address in that region returns zero.
// [RULE_03] Implementation is tracked per 32-byte block, one flag per block.
// [RULE_04] Empty blocks hold nothing; core/ICN/interrupts at 000h, timers 100h, system 700h; the map leaves 700h empty and sets 740h and 760h.
// [RULE_05] Data addresses 8000h and above may map onto a 16K-word program page.
// [RULE_06] Redirection happens only with address MSB set and core control bit 2 set.
// [RULE_07] An 8-bit page register selects one of 256 program pages.
// [RULE_08] Program address is the page as upper 8 bits over the low 15 address bits.
// [RULE_09] Only the low 16 bits of the 24-bit program word are returned.
// [RULE_10] A window read outside a loop stretches the instruction by one or two cycles for the second fetch.
// [RULE_11] The window is suspended while a table read or write runs.
// [RULE_12] Outside a loop, move adds one cycle and other instructions add two.
// [RULE_13] In a loop, first, last, interrupt exit and re-entry add two; others add none.
// [RULE_14] Loaders should fill the upper byte of window data with all ones or all zeros.
// [RULE_15] Byte reads take the whole word and the address LSB picks the byte.
// [RULE_16] With the window off or below 8000h, access goes to RAM or registers by address.
module dsd_decoder
  import dsd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Core access request
  input wire logic reqValid,
  input wire logic reqByte,
  input wire logic [dsd_pkg::EA_W-1:0] effectiveAddress,
  input wire logic [dsd_pkg::EA_W-1:0] coreControl,
  input wire logic [dsd_pkg::PAGE_W-1:0] progWindowPage,
  input wire logic tableAccessActive,
  // Instruction context for timing
  input wire logic isMoveInstr,
  input wire logic inRepeatLoop,
  input wire logic loopFirstIter,
  input wire logic loopLastIter,
  input wire logic loopIrqExit,
  input wire logic loopIrqReentry,
  // Downstream read data
  input wire logic [dsd_pkg::PROG_WORD_W-1:0] progReadWord,
  input wire logic [dsd_pkg::DATA_W-1:0] ramReadData,
  input wire logic [dsd_pkg::DATA_W-1:0] sfrReadData,
  // Routing outputs
  output logic [1:0] route,
  output logic ramSelect,
  output logic sfrSelect,
  output logic sfrImplemented,
  output logic progSelect,
  output logic [dsd_pkg::PROG_ADDR_W-1:0] progAddress,
  output logic [1:0] extraCycles,
  output logic stall,
  // Registered read result
  output logic [dsd_pkg::DATA_W-1:0] readData,
  output logic readValid
);
  import dsd_pkg::*;

  function automatic logic blockImplemented(input logic [EA_W-1:0] addr);
    logic [5:0] idx;
    idx = addr[10:SFR_BLOCK_SHIFT];
    return SFR_BLOCK_MAP[idx]; // [RULE_03] [RULE_04]
  endfunction

  // Loop context wins over the instruction kind, since the loop hides the second fetch
  function automatic logic [1:0] extraFor(input logic inLoop, input logic slow, input logic isMove);
    logic [1:0] cyc;
    if (inLoop) begin
      cyc = slow ? EXTRA_TWO : EXTRA_NONE; // [RULE_13]
    end else if (isMove) begin
      cyc = EXTRA_ONE; // [RULE_12] [RULE_10]
    end else begin
      cyc = EXTRA_TWO; // [RULE_12]
    end
    return cyc;
  endfunction

  wire logic inSfr = (effectiveAddress <= SFR_LAST); // [RULE_01]
  wire logic winEnable = coreControl[CORE_CTRL_WIN_BIT];
  // Table instructions reach program memory themselves, so the window steps aside
  wire logic winHit = effectiveAddress[EA_W-1] && winEnable && !tableAccessActive; // [RULE_06] [RULE_11]
  wire logic sfrHit = !winHit && inSfr; // [RULE_16]
  wire logic ramHit = !winHit && !inSfr; // [RULE_16]
  wire logic sfrImpl = sfrHit && blockImplemented(effectiveAddress);
  wire logic loopSlow = loopFirstIter || loopLastIter || loopIrqExit || loopIrqReentry;
  wire logic [1:0] winExtra = extraFor(inRepeatLoop, loopSlow, isMoveInstr); // [RULE_12] [RULE_13]
  wire logic [1:0] next_extra = (reqValid && winHit) ? winExtra : EXTRA_NONE;
  wire logic [DATA_W-1:0] sfrData = sfrImpl ? sfrReadData : {DATA_W{1'b0}}; // [RULE_02]
  wire logic [DATA_W-1:0] progData = progReadWord[DATA_W-1:0]; // [RULE_09] [RULE_14]
  wire logic [DATA_W-1:0] wordData = winHit ? progData : (sfrHit ? sfrData : ramReadData);
  wire logic [DATA_W-1:0] byteData = {8'h00, effectiveAddress[0] ? wordData[15:8] : wordData[7:0]}; // [RULE_15]
  wire logic [DATA_W-1:0] next_readData = reqByte ? byteData : wordData;

  assign route = winHit ? DSD_RT_PROG : (sfrHit ? DSD_RT_SFR : DSD_RT_RAM);
  assign ramSelect = reqValid && ramHit;
  assign sfrSelect = reqValid && sfrHit;
  assign sfrImplemented = sfrImpl;
  assign progSelect = reqValid && winHit; // [RULE_05]
  assign progAddress = {progWindowPage, effectiveAddress[WIN_LOW_W-1:0]}; // [RULE_07] [RULE_08]
  assign extraCycles = next_extra;
  assign stall = next_extra != EXTRA_NONE;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      readData <= READ_DATA_RST;
      readValid <= 1'b0;
    end else begin
      readData <= reqValid ? next_readData : readData;
      readValid <= reqValid;
    end
  end

  AST_UNUSED_SFR_ZERO: // [RULE_02]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid && !reqByte && sfrHit && !blockImplemented(effectiveAddress) |=> readData == 16'h0000)
    else $error("unimplemented register read not zero");
  AST_SFR_RANGE: // [RULE_01]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid && !winHit && effectiveAddress <= 16'h07ff |-> sfrSelect && !ramSelect)
    else $error("register region not selected");
  AST_EMPTY_BLOCK: // [RULE_04]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    sfrHit && effectiveAddress[10:5] == 6'h07 |-> !sfrImplemented)
    else $error("empty block reported implemented");
  AST_CORE_BLOCK: // [RULE_03]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    sfrHit && effectiveAddress[10:5] == 6'h00 |-> sfrImplemented)
    else $error("core block not implemented");
  AST_WIN_COND: // [RULE_06]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    progSelect |-> effectiveAddress[15] && coreControl[2] && !tableAccessActive)
    else $error("window used without enable");
  AST_TABLE_SUSPEND: // [RULE_11]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    tableAccessActive |-> !progSelect)
    else $error("window active during table access");
  AST_PROG_ADDR: // [RULE_08]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    progSelect |-> progAddress[22:15] == progWindowPage && progAddress[14:0] == effectiveAddress[14:0])
    else $error("window program address wrong");
  AST_WIN_DATA: // [RULE_09]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    progSelect && !reqByte |=> readData == $past(progReadWord[15:0]))
    else $error("window data wrong");
  AST_EXTRA_OUTSIDE: // [RULE_12]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    progSelect && !inRepeatLoop |-> extraCycles == (isMoveInstr ? 2'h1 : 2'h2))
    else $error("wrong extra cycles outside loop");
  AST_EXTRA_LOOP: // [RULE_13]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    progSelect && inRepeatLoop |-> extraCycles == (loopSlow ? 2'h2 : 2'h0))
    else $error("wrong extra cycles in loop");
  AST_BYTE_SEL: // [RULE_15]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid && reqByte && ramHit && effectiveAddress[0] |=> readData == {8'h00, $past(ramReadData[15:8])})
    else $error("byte lane wrong");
  AST_RAM_ROUTE: // [RULE_16]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid && (!coreControl[2] || !effectiveAddress[15]) && effectiveAddress > 16'h07ff |-> ramSelect)
    else $error("low address not routed to RAM");
  AST_STALL_EQ: // [RULE_12]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    stall == (extraCycles != 2'h0))
    else $error("stall disagrees with extra cycles");
  AST_NO_EXTRA_IDLE: // [RULE_10]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    !progSelect |-> extraCycles == 2'h0)
    else $error("extra cycles without window access");
  AST_WIN_READ_EXTRA: // [RULE_10]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    progSelect && !inRepeatLoop |-> extraCycles != 2'h0)
    else $error("window read not stretched");
  AST_SELECT_ONEHOT: // [RULE_16]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    $onehot0({ramSelect, sfrSelect, progSelect}))
    else $error("more than one target selected");
  AST_IDLE_NO_SELECT: // [RULE_16]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    !reqValid |-> !ramSelect && !sfrSelect && !progSelect)
    else $error("target selected without request");
  AST_WIN_ROUTE: // [RULE_05]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid && effectiveAddress[15] && coreControl[2] && !tableAccessActive |-> progSelect && route == DSD_RT_PROG)
    else $error("window access not redirected");
  AST_WIN_OFF_LOW: // [RULE_16]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    !coreControl[2] && effectiveAddress <= 16'h07ff |-> route == DSD_RT_SFR)
    else $error("register address not routed to registers");
  AST_SFR_WORD_DATA: // [RULE_02]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid && !reqByte && sfrHit && sfrImplemented |=> readData == $past(sfrReadData))
    else $error("register read data wrong");
  AST_RAM_WORD_DATA: // [RULE_16]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid && !reqByte && ramHit |=> readData == $past(ramReadData))
    else $error("RAM read data wrong");
  AST_BYTE_LOW: // [RULE_15]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid && reqByte && ramHit && !effectiveAddress[0] |=> readData == {8'h00, $past(ramReadData[7:0])})
    else $error("low byte lane wrong");
  AST_WIN_BYTE: // [RULE_09]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    progSelect && reqByte && effectiveAddress[0] |=> readData == {8'h00, $past(progReadWord[15:8])})
    else $error("window byte read wrong");
  AST_READ_VALID: // [RULE_16]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid |=> readValid)
    else $error("read result not flagged");
  AST_READ_IDLE: // [RULE_16]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    !reqValid |=> !readValid && $stable(readData))
    else $error("read result changed without request");
  AST_PAGE_FIELD: // [RULE_07]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    progAddress[22:15] == progWindowPage)
    else $error("page field not from page register");
  AST_TABLE_ROUTE: // [RULE_11]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    reqValid && tableAccessActive && effectiveAddress[15] |-> ramSelect)
    else $error("table access not routed normally");
  AST_LOOP_FAST: // [RULE_13]
    assert property (@(posedge ref_clk) disable iff (!nrst)
    progSelect && inRepeatLoop && !loopSlow |-> !stall)
    else $error("steady loop iteration stalled");
endmodule

// File: verification/dsd_core_model.sv
`timescale 1ns/1ps
module dsd_core_model (
  // Clock
  input wire logic ref_clk,
  // Target read data
  output logic [23:0] progReadWord,
  output logic [15:0] ramReadData,
  output logic [15:0] sfrReadData
);
  logic [15:0] cnt = 16'h1357;
  // Fresh pattern each cycle, so a stale capture never matches by luck
  always @(posedge ref_clk) begin
    #2 cnt = cnt * 16'h0005 + 16'h3a1d;
  end
  assign progReadWord = {{8{cnt[3]}}, cnt ^ 16'h5a3c};
  assign ramReadData = cnt;
  assign sfrReadData = ~cnt;
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dsd_pkg::*;
  logic ref_clk = 0, nrst = 0, reqValid = 0, reqByte = 0, tableAccessActive = 0;
  logic isMoveInstr = 0, inRepeatLoop = 0, loopFirstIter = 0, loopLastIter = 0;
  logic loopIrqExit = 0, loopIrqReentry = 0, ramSelect, sfrSelect, sfrImplemented;
  logic progSelect, stall, readValid, win, eV = 0;
  logic [15:0] effectiveAddress = 0, coreControl = 0, ramReadData, sfrReadData, readData;
  logic [15:0] raw, eD = 0;
  logic [7:0] progWindowPage = 0;
  logic [23:0] progReadWord;
  logic [22:0] progAddress;
  logic [1:0] route, extraCycles, er, ex;
  logic [15:0] corner [6] = '{16'h0000, 16'h07ff, 16'h0800, 16'h7fff, 16'h8000, 16'hffff};
  int failures = 0, cmp_count = 0, seed = 32'h774d;
  initial forever #12.5 ref_clk = ~ref_clk;
  dsd_decoder dsd_decoder_i(.ref_clk, .nrst, .reqValid, .reqByte, .effectiveAddress,
    .coreControl, .progWindowPage, .tableAccessActive, .isMoveInstr, .inRepeatLoop,
    .loopFirstIter, .loopLastIter, .loopIrqExit, .loopIrqReentry, .progReadWord,
    .ramReadData, .sfrReadData, .route, .ramSelect, .sfrSelect, .sfrImplemented,
    .progSelect, .progAddress, .extraCycles, .stall, .readData, .readValid);
  dsd_core_model dsd_core_model_i(.ref_clk, .progReadWord, .ramReadData, .sfrReadData);
  task chk(input string n, input logic [22:0] s, input logic [22:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 nrst = 1;
    chk("readValid", readValid, 0);
    chk("readData", readData, 0);
    $display("test reset done");
    for (int i = 0; i < 800; i++) begin
      @(posedge ref_clk);
      #1 chk("readValid", readValid, eV);
      chk("readData", readData, eD);
      {reqByte, isMoveInstr, inRepeatLoop, loopFirstIter, loopLastIter, loopIrqExit,
        loopIrqReentry} = 7'($random(seed));
      reqValid = ($random(seed) & 3) != 0;
      nrst = !(i >= 400 && i < 402);
      effectiveAddress = i < 6 ? corner[i] : 16'($random(seed));
      if (i % 3 == 0 && i >= 6) effectiveAddress &= 16'h07ff;
      coreControl = 16'($random(seed));
      progWindowPage = 8'($random(seed));
      tableAccessActive = ($random(seed) & 3) == 0;
      #10 win = effectiveAddress[15] & coreControl[2] & !tableAccessActive;
      er = win ? DSD_RT_PROG : (effectiveAddress <= SFR_LAST ? DSD_RT_SFR : DSD_RT_RAM);
      ex = !(win && reqValid) ? EXTRA_NONE : inRepeatLoop ?
        ((loopFirstIter | loopLastIter | loopIrqExit | loopIrqReentry) ? EXTRA_TWO : EXTRA_NONE)
        : (isMoveInstr ? EXTRA_ONE : EXTRA_TWO);
      chk("route", route, er);
      chk("selects", {ramSelect, sfrSelect, progSelect}, {reqValid && er == DSD_RT_RAM,
        reqValid && er == DSD_RT_SFR, reqValid && win});
      if (win) chk("progAddress", progAddress, {progWindowPage, effectiveAddress[14:0]});
      chk("extraCycles", extraCycles, ex);
      chk("stall", stall, ex != 0);
      if (er == DSD_RT_SFR) chk("sfrImplemented", sfrImplemented,
        SFR_BLOCK_MAP[effectiveAddress[10:5]]);
      raw = er == DSD_RT_PROG ? progReadWord[15:0] : er == DSD_RT_RAM ? ramReadData :
        (SFR_BLOCK_MAP[effectiveAddress[10:5]] ? sfrReadData : 16'h0000);
      if (reqValid) eD = reqByte ? {8'h00, effectiveAddress[0] ? raw[15:8] : raw[7:0]} : raw;
      eV = reqValid;
      if (!nrst) begin
        eV = 0;
        eD = 16'h0000;
      end
    end
    $display("test random traffic done");
    summarize;
  end
endmodule
